// >>> temp_zone_pkg.sv
// Constants for the battery temperature-zone configuration block.
// Assumes temperatures arrive as signed half-degree-Celsius codes.
package temp_zone_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_NTC_BASE      = 8'h1c;
  localparam logic [7:0] ADDR_THRESH_SEL    = 8'h1d;
  localparam logic [7:0] ADDR_WARM_ADJ      = 8'h1e;
  localparam logic [7:0] ADDR_COOL_ADJ      = 8'h1f;
  localparam logic [7:0] ADDR_STATE_FLAGS   = 8'h20;
  localparam logic [7:0] ADDR_ZONE_STAT     = 8'h22;

  // Reset values
  localparam logic [7:0] RST_NTC_BASE       = 8'h0f;
  localparam logic [7:0] RST_THRESH_SEL     = 8'h85;
  localparam logic [7:0] RST_WARM_ADJ       = 8'h7f;
  localparam logic [7:0] RST_COOL_ADJ       = 8'h df;

  // Field positions (low bit of each 2-bit field, or the bit itself for bypass, cold and hot select)
  localparam int POS_HI    = 6;
  localparam int POS_MIDHI = 4;
  localparam int POS_MIDLO = 2;
  localparam int POS_LO    = 0;
  localparam int POS_BYPASS  = 7;
  localparam int POS_COLD_SEL = 1;
  localparam int POS_HOT_SEL  = 0;

  // Thresholds in half degrees C: base plus step per code for TH2..TH5, one fixed value per code for TH1 and TH6
  localparam logic signed [9:0] TH_STEP    = 10'sh005;
  localparam logic signed [9:0] TH2_BASE   = 10'sh00a;
  localparam logic signed [9:0] TH3_BASE   = 10'sh01e;
  localparam logic signed [9:0] TH4_BASE   = 10'sh041;
  localparam logic signed [9:0] TH5_BASE   = 10'sh055;
  localparam logic signed [9:0] TH1_CODE0  = -10'sh00a;
  localparam logic signed [9:0] TH1_CODE1  = 10'sh000;
  localparam logic signed [9:0] TH6_CODE0  = 10'sh06e;
  localparam logic signed [9:0] TH6_CODE1  = 10'sh078;

  // Adjustment results
  localparam logic [8:0] DROP_STEP_MV = 9'h064;
  localparam logic [6:0] PCT_SUSPEND  = 7'h00;
  localparam logic [6:0] PCT_LOW      = 7'h14;
  localparam logic [6:0] PCT_MID      = 7'h28;
  localparam logic [6:0] PCT_FULL     = 7'h64;
  localparam logic [1:0] CODE_KEEP    = 2'h3;

  // Temperature zones
  typedef enum logic [2:0] {
    ZONE_NORMAL  = 3'b000,
    ZONE_COLD    = 3'b001,
    ZONE_COOL    = 3'b010,
    ZONE_PRECOOL = 3'b011,
    ZONE_PREWARM = 3'b100,
    ZONE_WARM    = 3'b101,
    ZONE_HOT     = 3'b110
  } zone_t;

endpackage

// >>> battery_temp_zone_config.sv
// Temperature-zone configuration registers and zone classifier.
// Assumes a decoded register port (address, strobes) behind the serial
// interface, and a signed half-degree temperature code from the ADC.
//
// What this block does
// - Cool upper threshold select, 5 to 12.5 C
// - Pre-cool upper threshold select, 15 to 22.5 C
// - Pre-warm lower threshold select, 32.5 to 40 C
// - Warm lower threshold select, 42.5 to 50 C
// - Warm zone lowers voltage target per code
// - Warm zone suspends or scales charge current
// - Pre-warm zone lowers voltage target per code
// - Pre-warm zone suspends or scales charge current
// - Cool zone lowers voltage target per code
// - Cool zone suspends or scales charge current
// - Pre-cool zone lowers voltage target per code
// - Pre-cool zone suspends or scales charge current
// - Register reset restores 0x85, 0x7f, 0xdf
// - Hot limit select, 55 or 60 C
// - Bypass bit forces normal zone
`timescale 1ns/1ps

module battery_temp_zone_config
  import temp_zone_pkg::*;
(
  input  wire logic              sys_clk_i,       // 200 MHz clock
  input  wire logic              rst_i,           // Register reset, high
  input  wire logic [7:0]        reg_addr_i,      // Register offset
  input  wire logic [7:0]        reg_wdata_i,     // Write data
  input  wire logic              reg_wr_i,        // Write strobe
  input  wire logic              reg_rd_i,        // Read strobe
  input  wire logic [7:0]        state_flags_i,   // Charger status bits
  input  wire logic signed [9:0] batt_temp_i,     // Temp, half degree C
  output logic [7:0]             reg_rdata_o,     // Read data
  output logic                   reg_rvalid_o,    // Read data valid
  output logic [2:0]             zone_o,          // Current zone
  output logic [8:0]             volt_drop_mv_o,  // Voltage target drop
  output logic [6:0]             curr_pct_o,      // Current target pct
  output logic                   charge_suspend_o // Charging suspended
);

  localparam int NREG = 4;

  // Writable registers, index 0..3 maps to offsets 0x1c..0x1f
  logic [7:0] regs      [NREG];
  logic [7:0] next_regs [NREG];
  logic [7:0] rst_vals  [NREG];

  assign rst_vals[0] = RST_NTC_BASE;
  assign rst_vals[1] = RST_THRESH_SEL;
  assign rst_vals[2] = RST_WARM_ADJ;
  assign rst_vals[3] = RST_COOL_ADJ;

  // One write decoder per register entry
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (reg_wr_i && reg_addr_i == ADDR_NTC_BASE + 8'(gi)) begin
          next_regs[gi] = reg_wdata_i;
        end
      end
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          regs[gi] <= rst_vals[gi];
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // Named views of the fields
  logic                   temp_bypass;
  logic [1:0]             cool_upper_limit_sel;
  logic [1:0]             precool_upper_limit_sel;
  logic [1:0]             prewarm_lower_limit_sel;
  logic [1:0]             warm_lower_limit_sel;
  logic signed [9:0]      th1, th2, th3, th4, th5, th6;

  assign temp_bypass             = regs[0][POS_BYPASS];
  assign cool_upper_limit_sel    = regs[1][POS_HI+:2];
  assign precool_upper_limit_sel = regs[1][POS_MIDHI+:2];
  assign prewarm_lower_limit_sel = regs[1][POS_MIDLO+:2];
  assign warm_lower_limit_sel    = regs[1][POS_LO+:2];

  // Threshold lookup in half-degree units, 2.5 C steps for th2..th5, 5 C steps for th1 and th6
  assign th1 = regs[0][POS_COLD_SEL] ? TH1_CODE1 : TH1_CODE0;
  assign th2 = TH2_BASE + TH_STEP * $signed({8'h00, cool_upper_limit_sel});
  assign th3 = TH3_BASE + TH_STEP * $signed({8'h00, precool_upper_limit_sel});
  assign th4 = TH4_BASE + TH_STEP * $signed({8'h00, prewarm_lower_limit_sel});
  assign th5 = TH5_BASE + TH_STEP * $signed({8'h00, warm_lower_limit_sel});
  assign th6 = regs[0][POS_HOT_SEL] ? TH6_CODE1 : TH6_CODE0;

  function automatic logic [8:0] drop_of(input logic [1:0] code);
    drop_of = 9'(DROP_STEP_MV * 9'(CODE_KEEP - code));
  endfunction

  function automatic logic [6:0] pct_of(input logic [1:0] code);
    case (code)
      2'h0:    pct_of = PCT_SUSPEND;
      2'h1:    pct_of = PCT_LOW;
      2'h2:    pct_of = PCT_MID;
      default: pct_of = PCT_FULL;
    endcase
  endfunction

  // Zone classification and adjustment selection
  zone_t      next_zone;
  logic [1:0] vcode, icode;
  logic [8:0] next_drop;
  logic [6:0] next_pct;
  logic       next_suspend;

  always_comb begin
    if (temp_bypass) begin
      next_zone = ZONE_NORMAL;
    end else if (batt_temp_i < th1) begin
      next_zone = ZONE_COLD;
    end else if (batt_temp_i < th2) begin
      next_zone = ZONE_COOL;
    end else if (batt_temp_i < th3) begin
      next_zone = ZONE_PRECOOL;
    end else if (batt_temp_i >= th6) begin
      next_zone = ZONE_HOT;
    end else if (batt_temp_i >= th5) begin
      next_zone = ZONE_WARM;
    end else if (batt_temp_i >= th4) begin
      next_zone = ZONE_PREWARM;
    end else begin
      next_zone = ZONE_NORMAL;
    end
  end

  // Only the active zone's field pair reaches the charge loop
  always_comb begin
    case (next_zone)
      ZONE_WARM: begin
        vcode = regs[2][POS_HI+:2];
        icode = regs[2][POS_MIDHI+:2];
      end
      ZONE_PREWARM: begin
        vcode = regs[2][POS_MIDLO+:2];
        icode = regs[2][POS_LO+:2];
      end
      ZONE_COOL: begin
        vcode = regs[3][POS_HI+:2];
        icode = regs[3][POS_MIDHI+:2];
      end
      ZONE_PRECOOL: begin
        vcode = regs[3][POS_MIDLO+:2];
        icode = regs[3][POS_LO+:2];
      end
      ZONE_COLD, ZONE_HOT: begin
        vcode = CODE_KEEP;
        icode = 2'h0; // Outside all zones charging stops
      end
      default: begin
        vcode = CODE_KEEP;
        icode = CODE_KEEP;
      end
    endcase
    next_drop    = drop_of(vcode);
    next_pct     = pct_of(icode);
    next_suspend = (icode == 2'h0);
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] next_rdata;
  always_comb begin
    case (reg_addr_i)
      ADDR_NTC_BASE:    next_rdata = regs[0];
      ADDR_THRESH_SEL:  next_rdata = regs[1];
      ADDR_WARM_ADJ:    next_rdata = regs[2];
      ADDR_COOL_ADJ:    next_rdata = regs[3];
      ADDR_STATE_FLAGS: next_rdata = state_flags_i;
      ADDR_ZONE_STAT:   next_rdata = {5'h00, zone_o};
      default:          next_rdata = 8'h00;
    endcase
  end

  // Outputs registered so the charge loop sees glitch-free targets
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      zone_o           <= ZONE_NORMAL;
      volt_drop_mv_o   <= 9'h000;
      curr_pct_o       <= PCT_FULL;
      charge_suspend_o <= 1'b0;
      reg_rdata_o      <= 8'h00;
      reg_rvalid_o     <= 1'b0;
    end else begin
      zone_o           <= next_zone;
      volt_drop_mv_o   <= next_drop;
      curr_pct_o       <= next_pct;
      charge_suspend_o <= next_suspend;
      reg_rdata_o      <= reg_rd_i ? next_rdata : 8'h00;
      reg_rvalid_o     <= reg_rd_i;
    end
  end

  property p_reset_vals;
    @(posedge sys_clk_i) $past(rst_i) |-> regs[1] == 8'h85 &&
      regs[2] == 8'h7f && regs[3] == 8'hdf;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset values wrong");

  property p_write_acts;
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ADDR_THRESH_SEL) |=>
      regs[1] == $past(reg_wdata_i);
  endproperty
  a_write_acts: assert property (p_write_acts)
    else $error("threshold write not stored");

  property p_readback;
    @(posedge sys_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == ADDR_WARM_ADJ && !reg_wr_i) |=>
      reg_rvalid_o && reg_rdata_o == regs[2];
  endproperty
  a_readback: assert property (p_readback)
    else $error("warm adjust readback wrong");

  property p_bypass;
    @(posedge sys_clk_i) disable iff (rst_i)
    temp_bypass |=> zone_o == ZONE_NORMAL && curr_pct_o == PCT_FULL;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass did not force normal");

  property p_warm_zone;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!temp_bypass && batt_temp_i >= th5 && batt_temp_i < th6 &&
     th5 > th3) |=> zone_o == ZONE_WARM &&
      volt_drop_mv_o == 9'd100 * (9'd3 - 9'($past(regs[2][7:6])));
  endproperty
  a_warm_zone: assert property (p_warm_zone)
    else $error("warm zone voltage drop wrong");

  property p_warm_suspend;
    @(posedge sys_clk_i) disable iff (rst_i)
    (next_zone == ZONE_WARM && regs[2][5:4] == 2'b00) |=>
      charge_suspend_o && curr_pct_o == 7'd0;
  endproperty
  a_warm_suspend: assert property (p_warm_suspend)
    else $error("warm zone suspend missing");

  property p_cool_curr;
    @(posedge sys_clk_i) disable iff (rst_i)
    (next_zone == ZONE_COOL && regs[3][5:4] == 2'b01) |=>
      curr_pct_o == 7'd20 && !charge_suspend_o;
  endproperty
  a_cool_curr: assert property (p_cool_curr)
    else $error("cool zone current not 20 pct");

  property p_normal_band;
    @(posedge sys_clk_i) disable iff (rst_i)
    (batt_temp_i >= th3 && batt_temp_i < th4 && th4 < th5) |=>
      zone_o == ZONE_NORMAL && volt_drop_mv_o == 9'd0;
  endproperty
  a_normal_band: assert property (p_normal_band)
    else $error("normal band misclassified");

  property p_cool_bound;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!temp_bypass && regs[1][7:6] == 2'b10 && batt_temp_i == 10'sd19 &&
     batt_temp_i >= th1) |=> zone_o == ZONE_COOL;
  endproperty
  a_cool_bound: assert property (p_cool_bound)
    else $error("cool threshold code 10 not 10 C");

endmodule

// >>> testbench.sv
// Self-checking bench for the temperature-zone configuration block.
// Assumes the decoded register port and the one-cycle answers of the note.
`timescale 1ns/1ps

module testbench;
  import temp_zone_pkg::*;

  logic              sys_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic [7:0]        reg_addr_i = 8'h00;
  logic [7:0]        reg_wdata_i = 8'h00;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [7:0]        state_flags_i = 8'h00;
  logic signed [9:0] batt_temp_i = 10'sh028;
  logic [7:0]        reg_rdata_o;
  logic              reg_rvalid_o;
  logic [2:0]        zone_o;
  logic [8:0]        volt_drop_mv_o;
  logic [6:0]        curr_pct_o;
  logic              charge_suspend_o;
  logic [7:0]  rd_q[$];
  logic [19:0] z_q[$];
  logic        zlook = 1'b0;
  logic [7:0]  m1c, m1d, m1e, m1f;
  logic [31:0] lfsr = 32'h8d36;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;

  battery_temp_zone_config battery_temp_zone_config_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .state_flags_i(state_flags_i), .batt_temp_i(batt_temp_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .zone_o(zone_o), .volt_drop_mv_o(volt_drop_mv_o),
    .curr_pct_o(curr_pct_o), .charge_suspend_o(charge_suspend_o));

  // 200 MHz clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  function automatic logic [7:0] rnd();
    lfsr = lfsr[0] ? ((lfsr >> 1) ^ 32'h80200003) : (lfsr >> 1);
    return lfsr[7:0];
  endfunction

  // Expected zone outputs from the bench's own register copy
  function automatic logic [19:0] expv(int t);
    int th1, th2, th3, th4, th5, th6;
    logic [2:0] z;
    logic [1:0] v, c;
    th1 = m1c[1] ? 0 : -10;
    th2 = 10 + 5 * m1d[7:6];
    th3 = 30 + 5 * m1d[5:4];
    th4 = 65 + 5 * m1d[3:2];
    th5 = 85 + 5 * m1d[1:0];
    th6 = m1c[0] ? 120 : 110;
    z = 3'h0;
    if (m1c[7]) z = 3'h0;
    else if (t < th1) z = 3'h1;
    else if (t < th2) z = 3'h2;
    else if (t < th3) z = 3'h3;
    else if (t >= th6) z = 3'h6;
    else if (t >= th5) z = 3'h5;
    else if (t >= th4) z = 3'h4;
    case (z)
      3'h2: {v, c} = m1f[7:4];
      3'h3: {v, c} = m1f[3:0];
      3'h4: {v, c} = m1e[3:0];
      3'h5: {v, c} = m1e[7:4];
      default: {v, c} = 4'hf;
    endcase
    return {z, 9'((3 - v) * 100), (c == 2'h0) ? 7'h00 : (c == 2'h1) ?
            7'h14 : (c == 2'h2) ? 7'h28 : 7'h64, c == 2'h0};
  endfunction

  task automatic cmp(logic [19:0] got, logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Result watcher: oldest note against each answer
  always @(negedge sys_clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (rd_q.size() == 0) cmp({12'h0, reg_rdata_o}, 20'hxxxxx);
      else cmp({12'h0, reg_rdata_o}, {12'h0, rd_q.pop_front()});
    end
    if (zlook) begin
      cmp({zone_o, volt_drop_mv_o, curr_pct_o, charge_suspend_o},
          z_q.pop_front());
    end
  end

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk_i) #1;
    {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(posedge sys_clk_i) #1;
    reg_wr_i = 1'b0;
    if (a == ADDR_NTC_BASE) m1c = d;
    if (a == ADDR_THRESH_SEL) m1d = d;
    if (a == ADDR_WARM_ADJ) m1e = d;
    if (a == ADDR_COOL_ADJ) m1f = d;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge sys_clk_i) #1;
    rd_q.push_back(e);
    {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(posedge sys_clk_i) #1;
    reg_rd_i = 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic tchk(int t);
    @(posedge sys_clk_i) #1;
    batt_temp_i = 10'(t);
    repeat (2) @(posedge sys_clk_i);
    #1 z_q.push_back(expv(t));
    zlook = 1'b1;
    @(posedge sys_clk_i) #1 zlook = 1'b0;
  endtask

  // Temperatures on both sides of th2..th5; th1 only at the threshold, th6 only one code below
  task automatic sweep();
    int b[5];
    b = '{m1c[1] ? 0 : -10, 10 + 5 * m1d[7:6], 30 + 5 * m1d[5:4],
          65 + 5 * m1d[3:2], 85 + 5 * m1d[1:0]};
    for (int i = 0; i < 5; i++) begin
      tchk(b[i] - 1 + (i == 0));
      tchk(b[i]);
    end
    tchk((m1c[0] ? 120 : 110) - 1);
  endtask

  task automatic rst_regs();
    {m1c, m1d, m1e, m1f} = 32'h0f85_7fdf;
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    rst_regs();
    repeat (5) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    rd(ADDR_THRESH_SEL, 8'h85);
    rd(ADDR_WARM_ADJ, 8'h7f);
    rd(ADDR_COOL_ADJ, 8'hdf);
    rd(8'h30, 8'h00);
    sweep();
    $display("test reset_values done");
    for (int k = 0; k < 10; k++) begin
      for (int r = 0; r < 4; r++) begin
        wr(8'h1c + 8'(r), k < 4 ? 8'(k * 8'h55) & (r == 0 ? 8'h03 : 8'hff)
           : rnd() & (r == 0 ? 8'h03 : 8'hff));
      end
      rd(ADDR_THRESH_SEL, m1d);
      rd(ADDR_WARM_ADJ, m1e);
      rd(ADDR_COOL_ADJ, m1f);
      sweep();
    end
    $display("test code_sweep done");
    wr(ADDR_NTC_BASE, 8'h81);
    sweep();
    $display("test bypass done");
    state_flags_i = rnd();
    rd(ADDR_STATE_FLAGS, state_flags_i);
    // Read and write in one cycle: read sees the old value
    @(posedge sys_clk_i) #1;
    rd_q.push_back(m1e);
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = {ADDR_WARM_ADJ, 8'h24, 2'b11};
    @(posedge sys_clk_i) #1;
    {reg_wr_i, reg_rd_i} = 2'b00;
    m1e = 8'h24;
    rd(ADDR_WARM_ADJ, 8'h24);
    $display("test rw_same_cycle done");
    @(posedge sys_clk_i) #1 rst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    rst_regs();
    rd(ADDR_THRESH_SEL, 8'h85);
    rd(ADDR_WARM_ADJ, 8'h7f);
    rd(ADDR_COOL_ADJ, 8'hdf);
    sweep();
    $display("test mid_reset done");
    test_done();
  end

endmodule
